// ==== pp_clock_divider_consts.svh ====
// Constant values shared by the push-pull clock divider
`ifndef PP_CLOCK_DIVIDER_CONSTS_SVH
`define PP_CLOCK_DIVIDER_CONSTS_SVH

// Reset level of every divider stage and every output
`define DIV_RST_VAL   1'b0
`define OUT_RST_VAL   1'b0

// Select pin levels
`define SEL_LOW       1'b0
`define SEL_HIGH      1'b1

// Oscillator period in clk cycles (clk carries both oscillator edges)
`define OSC_PERIOD_CLKS 2

`endif

// ==== pp_clock_divider_pkg.sv ====
// Types for the push-pull clock divider
package pp_clock_divider_pkg;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_X1,
    MODE_X2,
    MODE_X4
  } ratio_mode_e;

  typedef struct packed {
    logic ratio_select_hi;
    logic ratio_select_lo;
  } ratio_select_s;

  typedef struct packed {
    logic sync_clk;
    logic gate_drive_a;
    logic gate_drive_b;
  } drive_out_s;

endpackage : pp_clock_divider_pkg

// ==== pp_div_sva.sv ====
// Port checks for the push-pull clock divider
module pp_div_sva (
  // Watched ports
  input wire logic                                clk,
  input wire logic                                rst_n,
  input wire pp_clock_divider_pkg::ratio_select_s sel,
  input wire pp_clock_divider_pkg::drive_out_s    drv
);
  wire [1:0] m = sel;
  wire       a = drv.gate_drive_a;
  wire       sc = drv.sync_clk;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_fast; (m == 2'h2 || m == 2'h3) [*2]; endsequence
  a_drive_compl: assert property (m != 2'h0 |=> a != drv.gate_drive_b)
    else $error("not complementary");
  a_off_quiet: assert property (m == 2'h0 |=> drv == 3'h0)
    else $error("not off");
  a_quarter_low: assert property ($fell(a) && m == 2'h3 |=> !a [*3] ##1 (a || m == 2'h0))
    else $error("quarter low");
  a_half_low: assert property ($fell(a) && m[0] != m[1] |=> !a ##1 (a || m == 2'h0))
    else $error("half low");
  a_high_duty: assert property ($rose(a) && m == 2'h3 |=> (a || m == 2'h0) [*3] ##1 !a)
    else $error("high time");
  a_fast_sync: assert property (s_fast |-> sc != $past(sc))
    else $error("fast sync");
  a_slow_sync: assert property (m == 2'h1 [*2] |-> sc == a)
    else $error("slow sync");
  a_edge_align: assert property (s_fast ##0 $changed(a) |-> $fell(sc))
    else $error("edge align");
endmodule : pp_div_sva

// ==== push_pull_clock_divider.sv ====
// Divider and ratio select logic for the push-pull gate drive outputs
`include "pp_clock_divider_consts.svh"

// What this block does
// - Drives toggle at half or quarter oscillator, 50%
// - Ratio four divides oscillator by four
// - Ratio one or two divides by two
// - Selects choose clock output frequency
// - Both selects low disables all outputs
// - Drive outputs are complementary while enabled, both low when off
module push_pull_clock_divider (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Ratio selects
  input  wire pp_clock_divider_pkg::ratio_select_s sel,
  // Drive and synchronizing clock outputs
  output      pp_clock_divider_pkg::drive_out_s    drv
);
  import pp_clock_divider_pkg::*;

  // Select pattern to ratio mode; both low parks everything
  function automatic ratio_mode_e decode_mode(input ratio_select_s s);
    ratio_mode_e m;
    m = MODE_OFF;
    case ({s.ratio_select_hi, s.ratio_select_lo})
      {`SEL_LOW, `SEL_HIGH}: begin
        m = MODE_X1;
      end
      {`SEL_HIGH, `SEL_LOW}: begin
        m = MODE_X2;
      end
      {`SEL_HIGH, `SEL_HIGH}: begin
        m = MODE_X4;
      end
      default: begin
        m = MODE_OFF;
      end
    endcase
    return m;
  endfunction : decode_mode

  // Any mode but the parked one lets the dividers run
  function automatic logic is_enabled(input ratio_mode_e md);
    logic en;
    en = 1'h0;
    if (md != MODE_OFF) begin
      en = 1'h1;
    end
    return en;
  endfunction : is_enabled

  // Next value of a toggle stage: flips when its carry-in is set
  function automatic logic toggle_step(input logic run, input logic cur, input logic carry);
    logic nxt;
    nxt = `DIV_RST_VAL;
    if (run) begin
      if (carry) begin
        nxt = ~cur;
      end else begin
        nxt = cur;
      end
    end
    return nxt;
  endfunction : toggle_step

  // Clock output source for each mode: half rate for ratio one,
  // oscillator rate for ratios two and four
  function automatic logic pick_sync(input ratio_mode_e md, input logic osc, input logic half);
    logic v;
    v = `OUT_RST_VAL;
    case (md)
      MODE_X1: begin
        v = half;
      end
      MODE_X2: begin
        v = osc;
      end
      MODE_X4: begin
        v = osc;
      end
      default: begin
        v = `OUT_RST_VAL;
      end
    endcase
    return v;
  endfunction : pick_sync

  // Drive source for each mode: half rate for ratios one and two,
  // quarter rate for ratio four
  function automatic logic pick_drive(input ratio_mode_e md, input logic half, input logic qtr);
    logic v;
    v = `OUT_RST_VAL;
    case (md)
      MODE_X1: begin
        v = half;
      end
      MODE_X2: begin
        v = half;
      end
      MODE_X4: begin
        v = qtr;
      end
      default: begin
        v = `OUT_RST_VAL;
      end
    endcase
    return v;
  endfunction : pick_drive

  // Decoded mode
  ratio_mode_e mode;
  logic        enabled;
  // Divider chain
  logic        osc_reg;
  logic        osc_next;
  logic        half_reg;
  logic        half_next;
  logic        quarter_reg;
  logic        quarter_next;
  // Output registers
  logic        sync_reg;
  logic        sync_next;
  logic        drive_a_reg;
  logic        drive_a_next;
  logic        drive_b_reg;
  logic        drive_b_next;

  assign mode    = decode_mode(sel);
  assign enabled = is_enabled(mode);

  // Oscillator-rate stage runs freely while enabled
  always_comb begin
    osc_next = toggle_step(enabled, osc_reg, 1'h1);
  end

  // Async reset parks every stage low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_reg <= `DIV_RST_VAL;
    end else begin
      osc_reg <= osc_next;
    end
  end

  // Half-rate stage flips when the oscillator stage is high
  always_comb begin
    half_next = toggle_step(enabled, half_reg, osc_reg);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= `DIV_RST_VAL;
    end else begin
      half_reg <= half_next;
    end
  end

  // Quarter-rate stage flips when both faster stages are high
  always_comb begin
    quarter_next = toggle_step(enabled, quarter_reg, osc_reg & half_reg);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quarter_reg <= `DIV_RST_VAL;
    end else begin
      quarter_reg <= quarter_next;
    end
  end

  // Outputs are picked from the next divider values so in ratios two and four every drive
  // edge lands on the same clock edge as a falling clock output edge
  always_comb begin
    sync_next = pick_sync(mode, osc_next, half_next);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= `OUT_RST_VAL;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Drive A is a toggle stage output, so it is high for half
  // of every period
  always_comb begin
    drive_a_next = pick_drive(mode, half_next, quarter_next);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_a_reg <= `OUT_RST_VAL;
    end else begin
      drive_a_reg <= drive_a_next;
    end
  end

  // Complement of drive A while running; both low while parked so
  // neither switch is left on
  always_comb begin
    if (enabled) begin
      drive_b_next = ~drive_a_next;
    end else begin
      drive_b_next = `OUT_RST_VAL;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_b_reg <= `OUT_RST_VAL;
    end else begin
      drive_b_reg <= drive_b_next;
    end
  end

  // Output bundle straight from the registers
  assign drv = '{sync_clk:     sync_reg,
                 gate_drive_a: drive_a_reg,
                 gate_drive_b: drive_b_reg};

endmodule : push_pull_clock_divider

// ==== push_pull_clock_divider_tb.sv ====
// Bench for the push-pull clock divider
module push_pull_clock_divider_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pp_clock_divider_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  ratio_select_s sel = 2'h0;
  drive_out_s    drv;
  logic [7:0]    edge_cnt;
  int            error_cnt = 0;
  int            samples_checked = 0;
  always #20 clk = ~clk;
  push_pull_clock_divider push_pull_clock_divider_i (.clk(clk), .rst_n(rst_n),
    .sel(sel), .drv(drv));
  pwm_sync_model pwm_sync_model_i (.clk(clk), .sync_clk(drv.sync_clk), .edge_cnt(edge_cnt));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic run_mode(logic [1:0] m, logic [7:0] sync_n, logic [7:0] a_n);
    logic [7:0] base;
    logic [7:0] rises;
    logic [7:0] highs;
    logic [7:0] b_highs;
    logic [7:0] same;
    logic       prev;
    sel = 2'h0;
    repeat (3) @(posedge clk);
    #1 sel = m;
    repeat (4) @(posedge clk);
    #1 base = edge_cnt;
    prev = drv.gate_drive_a;
    rises = 8'h00;
    highs = 8'h00;
    b_highs = 8'h00;
    same = 8'h00;
    repeat (32) begin
      @(posedge clk);
      #1 rises += {7'h00, drv.gate_drive_a & ~prev};
      highs += {7'h00, drv.gate_drive_a};
      b_highs += {7'h00, drv.gate_drive_b};
      same += {7'h00, drv.gate_drive_a ~^ drv.gate_drive_b};
      prev = drv.gate_drive_a;
    end
    check("sync rises", sync_n, edge_cnt - base);
    check("drive rises", a_n, rises);
    check("drive high", a_n ? 8'h10 : 8'h00, highs);
    check("drive b high", a_n ? 8'h10 : 8'h00, b_highs);
    check("drive a equals b", a_n ? 8'h00 : 8'h20, same);
    $display("mode %h done", m);
  endtask : run_mode
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    run_mode(2'h1, 8'h08, 8'h08);
    run_mode(2'h2, 8'h10, 8'h08);
    run_mode(2'h3, 8'h10, 8'h04);
    run_mode(2'h0, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule : push_pull_clock_divider_tb
bind push_pull_clock_divider pp_div_sva pp_div_sva_i (.clk(clk), .rst_n(rst_n), .sel(sel), .drv(drv));

// ==== pwm_sync_model.sv ====
// Controller model counting sync clock rises
module pwm_sync_model (
  // Clock and sync input
  input  wire logic       clk,
  input  wire logic       sync_clk,
  // Rises seen
  output      logic [7:0] edge_cnt
);
  logic last = 1'b0;
  initial edge_cnt = 8'h00;
  always @(posedge clk) begin
    last <= sync_clk;
    edge_cnt <= edge_cnt + {7'h00, sync_clk & ~last};
  end
endmodule : pwm_sync_model
